//--- dpm_pkg.sv
// package with constants for the dual-port memory port controller
// Overview of operation
// - right read of 3FFF clears right flag
// - unused interrupts leave mailboxes plain storage
// - stand-alone slave busy inputs held high
// - hold address valid before write pulse
// - one master per address range when widening
// - cascaded busy indications combined with AND
// - flag access: chip select high, flag select low
// - request with zero, release with one
package dpm_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam logic [13:0] LEFT_MBOX_ADDR  = 14'h3FFE;
  localparam logic [13:0] RIGHT_MBOX_ADDR = 14'h3FFF;
  localparam int FLAG_SEL_W = 3;
  // cycles address and select stand before the strobe falls
  localparam int SETUP_CYC  = 1;
  localparam int STROBE_CYC = 2;
  localparam int SAMPLE_CYC = 1; // strobe cycle on which read data is caught
  localparam logic [1:0] CMD_MEM_READ  = 2'h0;
  localparam logic [1:0] CMD_MEM_WRITE = 2'h1;
  localparam logic [1:0] CMD_FLAG_READ  = 2'h2;
  localparam logic [1:0] CMD_FLAG_WRITE = 2'h3;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_DONE   = 2'b11
  } dpm_state_type;
endpackage

//--- dpm_port_ctrl.sv
// controller that drives one port of the dual-port memory
`timescale 1ns/1ps
module dpm_port_ctrl
  import dpm_pkg::*;
#(
  parameter int P_ADDR_W = ADDR_W,
  parameter int P_DATA_W = DATA_W
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rstn,
  input  wire logic                i_req_valid,
  input  wire logic [1:0]          i_req_cmd,
  input  wire logic [P_ADDR_W-1:0] i_req_addr,
  input  wire logic [P_DATA_W-1:0] i_req_wdata,
  input  wire logic                i_mbox_addr_own,
  output logic                     o_req_ready,
  output logic                     o_rsp_valid,
  output logic [P_DATA_W-1:0]      o_rsp_rdata,
  output logic                     o_rsp_busy_seen,
  output logic                     o_irq,
  output logic                     o_chip_sel_n,
  output logic                     o_flag_space_select_n,
  output logic                     o_rw_n,
  output logic                     o_out_en_n,
  output logic                     o_upper_byte_sel_n,
  output logic                     o_lower_byte_sel_n,
  output logic [P_ADDR_W-1:0]      o_addr,
  output logic [P_DATA_W-1:0]      o_data_out,
  output logic                     o_data_oe,
  input  wire logic [P_DATA_W-1:0] i_data_in,
  input  wire logic                i_mailbox_irq_n,
  input  wire logic                i_conflict_n
);
  // elaboration-time checks of what the sequencer can serve
  initial begin
    if (P_ADDR_W != ADDR_W || P_DATA_W != DATA_W) begin
      $error("port widths must match the memory");
    end
    // the strobe counter is two bits wide
    if (STROBE_CYC < 1 || STROBE_CYC > 4) begin
      $error("strobe length out of counter range");
    end
    // read data is caught inside the strobe
    if (SAMPLE_CYC >= STROBE_CYC) begin
      $error("sample cycle outside the strobe");
    end
    // the state machine holds exactly one setup cycle
    if (SETUP_CYC != 1) begin
      $error("setup length not supported");
    end
  end

  dpm_state_type st_q;
  dpm_state_type st_d;
  logic [1:0]          cmd_q;
  logic [P_ADDR_W-1:0] addr_q;
  logic [P_DATA_W-1:0] wdata_q;
  logic [P_DATA_W-1:0] rdata_q;
  logic [1:0]          cnt_q;
  logic                busy_q;
  logic                rsp_q;

  // command decode
  wire is_write = cmd_q[0];
  wire is_flag  = cmd_q[1];
  wire active   = (st_q == ST_SETUP) || (st_q == ST_STROBE);
  wire strobing = (st_q == ST_STROBE);
  wire take     = (st_q == ST_IDLE) && i_req_valid;
  wire cnt_end  = (cnt_q == 2'(STROBE_CYC - 1));

  // semaphore access: memory select high, flag select low
  assign o_chip_sel_n          = !(active && !is_flag);
  assign o_flag_space_select_n = !(active && is_flag);
  // write strobe falls only after one setup cycle
  assign o_rw_n      = !(strobing && is_write);
  assign o_out_en_n  = !(strobing && !is_write);
  assign o_upper_byte_sel_n = !(active && !is_flag);
  assign o_lower_byte_sel_n = !active;
  assign o_addr      = addr_q;
  // flag writes carry the value on bit zero
  // zero requests a flag, one releases it
  assign o_data_out  = wdata_q;
  assign o_data_oe   = !(active && is_write); // low while driving
  assign o_req_ready = (st_q == ST_IDLE);
  assign o_rsp_valid = rsp_q;
  assign o_rsp_rdata = rdata_q;
  assign o_rsp_busy_seen = busy_q;
  // interrupt reported only when mailbox use enabled
  assign o_irq = i_mbox_addr_own && !i_mailbox_irq_n;

  // next-state selection
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:   if (i_req_valid) st_d = ST_SETUP;
      ST_SETUP:  st_d = ST_STROBE;
      ST_STROBE: if (cnt_end) st_d = ST_DONE;
      ST_DONE:   st_d = ST_IDLE;
    endcase
  end

  // request capture and sequencing
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_q    <= ST_IDLE;
      cmd_q   <= CMD_MEM_READ;
      addr_q  <= '0;
      wdata_q <= '0;
      cnt_q   <= '0;
    end else begin
      st_q <= st_d;
      if (take) begin
        cmd_q   <= i_req_cmd;
        addr_q  <= i_req_addr;
        wdata_q <= i_req_wdata;
      end
      cnt_q <= strobing ? cnt_q + 2'd1 : 2'd0;
    end
  end

  // fixed-length access, no wait on flags
  // read of own mailbox acknowledges the interrupt
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rdata_q <= '0;
      busy_q  <= 1'b0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= (st_q == ST_STROBE) && cnt_end;
      if (strobing && !is_write && cnt_q == 2'(SAMPLE_CYC)) begin
        rdata_q <= i_data_in;
      end
      // note a collision seen during the access
      // pin is the array's combined busy
      if (take) begin
        busy_q <= 1'b0;
      end else if (active && !i_conflict_n) begin
        busy_q <= 1'b1;
      end
    end
  end

  // all checks below run on the reference clock, off during reset
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // address stable during the write strobe
  a_addr_hold: assert property (
    !o_rw_n |->
      $stable(o_addr) && $past(!o_chip_sel_n || !o_flag_space_select_n))
    else $error("address moved or select late at write strobe");
  a_sel_excl: assert property (
    !o_chip_sel_n |->
      o_flag_space_select_n)
    else $error("both selects low");
  a_fixed_len: assert property (
    take |->
      ##4 o_rsp_valid)
    else $error("response not on time");
  a_standby: assert property (
    o_req_ready |->
      o_chip_sel_n && o_flag_space_select_n)
    else $error("idle port selected");
  a_setup_first: assert property (
    $fell(o_chip_sel_n) |->
      o_rw_n)
    else $error("write strobe with select");
  a_read_oe: assert property (
    take && i_req_cmd == CMD_MEM_READ |->
      ##2 !o_out_en_n [*2])
    else $error("read strobe missing");
  a_wdata: assert property (
    !o_data_oe |->
      $stable(o_data_out) || $past(o_data_oe))
    else $error("write data changed");
  a_busy_flag: assert property (
    active && !i_conflict_n |=>
      o_rsp_busy_seen)
    else $error("busy not recorded");
  a_rsp_pulse: assert property (
    o_rsp_valid |=>
      !o_rsp_valid && o_req_ready)
    else $error("response pulse too long");
  a_strobe_excl: assert property (
    !o_rw_n |->
      o_out_en_n)
    else $error("both strobes low");
  // flag access uses lower byte only
  a_flag_bytes: assert property (
    !o_flag_space_select_n |->
      o_upper_byte_sel_n && !o_lower_byte_sel_n)
    else $error("byte selects wrong on flag access");
  a_mem_bytes: assert property (
    !o_chip_sel_n |->
      !o_upper_byte_sel_n && !o_lower_byte_sel_n)
    else $error("byte selects wrong on memory access");
  // data pins driven under the write strobe
  a_oe_drive: assert property (
    !o_rw_n |->
      !o_data_oe)
    else $error("write strobe without driven data");

  // memory write taken
  c_mem_write: cover property (
    take && i_req_cmd == CMD_MEM_WRITE);
  // flag write taken
  c_flag_write: cover property (
    take && i_req_cmd == CMD_FLAG_WRITE);
  // flag read taken
  c_flag_read: cover property (
    take && i_req_cmd == CMD_FLAG_READ);
  // access that met a conflict
  c_busy: cover property (
    o_rsp_valid && o_rsp_busy_seen);
  // mailbox interrupt acknowledged
  c_irq_ack: cover property (
    o_irq ##1 !o_irq);
endmodule

//--- dpm_dev_model.sv
// device model: memory, mailbox flags, busy pin and flags
`timescale 1ns/1ps
module dpm_dev_model
  import dpm_pkg::*;
(
  input  wire logic        i_cs_n,
  input  wire logic        i_flag_n,
  input  wire logic        i_rw_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_upper_n,
  input  wire logic        i_lower_n,
  input  wire logic        i_drive_n,
  input  wire logic [13:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_far_cs_n,
  input  wire logic        i_far_rw_n,
  input  wire logic        i_far_oe_n,
  input  wire logic [13:0] i_far_addr,
  input  wire logic [15:0] i_far_data,
  output logic [15:0]      o_data,
  output logic             o_irq_n,
  output logic             o_far_irq_n,
  output logic             o_conflict_n
);
  logic [15:0] mem [0:16383];
  logic [7:0]  flag_q    = 8'hFF;
  logic        irq_q     = 1'b1;
  logic        far_irq_q = 1'b1;
  logic [15:0] last_q    = 16'h0000;
  wire         rd  = !i_oe_n && !(i_cs_n && i_flag_n);
  // undriven data pins show the inverse of the controller's value
  wire  [15:0] bus = i_drive_n ? ~i_data : i_data;
  wire         wr  = !i_cs_n && !i_rw_n && o_conflict_n;
  // master: far port wins a match
  // slave strap not modelled; busy pin is an output here
  assign o_conflict_n = !(!i_cs_n && !i_far_cs_n && i_addr == i_far_addr);
  assign o_irq_n      = irq_q;
  assign o_far_irq_n  = far_irq_q;
  // idle bus shows inverse, flags on all bits
  assign o_data = !rd ? ~last_q :
                  !i_cs_n ? mem[i_addr] : {16{flag_q[i_addr[2:0]]}};
  always @* if (rd) last_q = o_data;
  // byte-wise near-port memory writes, blocked while busy; far-port writes take whole words, never blocked
  always @* begin
    if (wr && !i_upper_n) mem[i_addr][15:8] = bus[15:8];
    if (wr && !i_lower_n) mem[i_addr][7:0] = bus[7:0];
    if (wr && i_addr == RIGHT_MBOX_ADDR) far_irq_q = 1'b0;
    if (i_cs_n && !i_flag_n && !i_rw_n) flag_q[i_addr[2:0]] = bus[0];
    if (!i_far_cs_n && !i_far_rw_n) begin
      mem[i_far_addr] = i_far_data;
      if (i_far_addr == LEFT_MBOX_ADDR) irq_q = 1'b0;
    end
    if (!i_far_cs_n && !i_far_oe_n && i_far_rw_n &&
        i_far_addr == RIGHT_MBOX_ADDR) far_irq_q = 1'b1;
    if (!i_cs_n && !i_oe_n && i_addr == LEFT_MBOX_ADDR) irq_q = 1'b1;
  end
endmodule

//--- tb.sv
// testbench: port controller against the device model
`timescale 1ns/1ps
module tb;
  import dpm_pkg::*;
  logic        clk = 0, rstn = 0, vld = 0, own = 0, fcs_n = 1, frw_n = 1;
  logic [1:0]  cmd = 0;
  logic [13:0] adr = 0, fadr = 0, a, pa;
  logic [15:0] wd = 0, fd = 0, d, mo, ra, dout;
  logic        rdy, rv, bs, irq, cs_n, sm_n, rw_n, oe_n, irq_n, cf_n;
  logic        foe_n = 1;
  logic        hi_n, lo_n, doe_n, firq_n;
  logic [17:0] q[$];
  logic [17:0] note;
  int          fails = 0, n_tests = 0, i;
  initial forever #20 clk = ~clk;
  dpm_port_ctrl dut (.i_ref_clk(clk), .i_rstn(rstn), .i_req_valid(vld),
    .i_req_cmd(cmd), .i_req_addr(adr), .i_req_wdata(wd),
    .i_mbox_addr_own(own), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(ra), .o_rsp_busy_seen(bs), .o_irq(irq),
    .o_chip_sel_n(cs_n), .o_flag_space_select_n(sm_n), .o_rw_n(rw_n),
    .o_out_en_n(oe_n), .o_upper_byte_sel_n(hi_n), .o_lower_byte_sel_n(lo_n),
    .o_addr(pa), .o_data_out(dout), .o_data_oe(doe_n), .i_data_in(mo),
    .i_mailbox_irq_n(irq_n), .i_conflict_n(cf_n));
  dpm_dev_model mdl (.i_cs_n(cs_n), .i_flag_n(sm_n), .i_rw_n(rw_n),
    .i_oe_n(oe_n), .i_upper_n(hi_n), .i_lower_n(lo_n), .i_drive_n(doe_n),
    .i_addr(pa), .i_data(dout), .i_far_cs_n(fcs_n), .i_far_rw_n(frw_n),
    .i_far_oe_n(foe_n), .i_far_addr(fadr), .i_far_data(fd), .o_data(mo),
    .o_irq_n(irq_n), .o_far_irq_n(firq_n), .o_conflict_n(cf_n));
  // verdict and end of run
  task summarize;
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // count one comparison
  task chk(input logic ok);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: response mismatch", $time);
    end
  endtask
  // issue one request; note = {check data, busy, data}
  task req(input logic [1:0] c, input logic [13:0] ad,
           input logic [15:0] dw, input logic [17:0] note);
    int n;
    q.push_back(note);
    vld <= 1'b1;
    cmd <= c;
    adr <= ad;
    wd <= dw;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    vld <= 1'b0;
    if (n >= 20) begin
      fails++;
      summarize;
    end
    @(posedge clk);
  endtask
  // compare each response against the oldest note
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("unexpected at %0t: response without request", $time);
      end else begin
        note = q.pop_front();
        chk(bs === note[16] && (!note[17] || ra === note[15:0]));
      end
    end
  end
  initial begin
    void'($urandom(15383));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(irq_n === 1'b1 && firq_n === 1'b1 && rdy === 1'b1);
    for (i = 0; i < 4; i++) begin
      a = 14'($urandom);
      d = 16'($urandom);
      req(CMD_MEM_WRITE, a, d, 18'h0_0000);
      req(CMD_MEM_READ, a, 16'h0000, {2'b10, d});
    end
    own <= 1'b1;
    fcs_n <= 1'b0;
    frw_n <= 1'b0;
    fadr <= LEFT_MBOX_ADDR;
    fd <= d;
    @(posedge clk);
    fcs_n <= 1'b1;
    frw_n <= 1'b1;
    @(posedge clk);
    chk(irq === 1'b1);
    req(CMD_MEM_READ, LEFT_MBOX_ADDR, 16'h0000, {2'b10, d});
    repeat (5) @(posedge clk);
    chk(irq === 1'b0);
    fcs_n <= 1'b0;
    fadr <= a;
    req(CMD_MEM_WRITE, a, ~d, 18'h1_0000);
    repeat (4) @(posedge clk);
    fcs_n <= 1'b1;
    req(CMD_MEM_READ, a, 16'h0000, {2'b10, d});
    req(CMD_MEM_WRITE, RIGHT_MBOX_ADDR, d, 18'h0_0000);
    repeat (4) @(posedge clk);
    chk(firq_n === 1'b0);
    fcs_n <= 1'b0;
    foe_n <= 1'b0;
    fadr <= RIGHT_MBOX_ADDR;
    @(posedge clk);
    fcs_n <= 1'b1;
    foe_n <= 1'b1;
    @(posedge clk);
    chk(firq_n === 1'b1);
    for (i = 0; i < 8; i++) begin
      a = {11'($urandom), i[2:0]};
      req(CMD_FLAG_WRITE, a, {15'h0000, i[0]}, 18'h0_0000);
      req(CMD_FLAG_READ, a, 16'h0000, {2'b10, {16{i[0]}}});
    end
    repeat (8) @(posedge clk);
    if (q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: response missing", $time);
    end
    summarize;
  end
endmodule
